// [hdl/strap_pkg.sv]
// shared constants and types for the strap address and image select block
package strap_pkg;
	// register offsets
	localparam logic [7:0] OFS_BASE_ADDR = 8'h40;
	localparam logic [7:0] OFS_OFFSET_CTRL = 8'h42;
	localparam logic [7:0] OFS_LFZ_1_4 = 8'h62;
	localparam logic [7:0] OFS_LFZ_0 = 8'h64;
	// field positions
	localparam int I2C_ADDR_LSB = 8;
	localparam int PMB_ADDR_LSB = 0;
	localparam int BYPASS_BIT = 6;
	localparam int LFZ0_LSB = 12;
	localparam int LFZ1_LSB = 0;
	localparam int LFZ2_LSB = 4;
	localparam int LFZ3_LSB = 8;
	localparam int LFZ4_LSB = 12;
	// reset values
	localparam logic [15:0] BASE_ADDR_RST = 16'h1010;
	localparam logic [15:0] OFFSET_CTRL_RST = 16'h0000;
	localparam logic [15:0] LFZ_1_4_RST = 16'h0000;
	localparam logic [15:0] LFZ_0_RST = 16'h0000;
	// strap limits
	localparam logic [3:0] MAX_PIN_OFFSET = 4'h4;
	localparam int NUM_IMAGES = 16;
	localparam int NUM_LFZ = 5;
	// image load sequencing
	localparam int IMAGE_WORDS = 4;
	// effective address pair
	typedef struct packed {
		logic [6:0] i2c;
		logic [6:0] pmb;
	} addr_pair_s;
	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_s;
	// non-volatile read request
	typedef struct packed {
		logic req;
		logic [3:0] image;
		logic [1:0] word;
	} nvm_req_s;
endpackage

// [hdl/strap_address_image_select.sv]
// strap decode, address offset and configuration image load
`timescale 1ns/100ps
module strap_address_image_select (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// strap band from the analog resistor comparator
	input wire logic [3:0] address_image_strap_pin,
	// non-volatile memory status and read port
	input wire logic multi_image_stored,
	input wire logic [3:0] last_programmed_image,
	output strap_pkg::nvm_req_s nvm_req,
	input wire logic nvm_ack,
	input wire logic [15:0] nvm_rdata,
	// register access from the serial port
	input strap_pkg::reg_req_s reg_req,
	output logic [15:0] reg_rdata,
	// results
	output strap_pkg::addr_pair_s eff_addr,
	output logic [3:0] strap_code,
	output logic load_done,
	output logic [14:0] loop_filter_zero_select
);
	import strap_pkg::*;

	// ****************************************
	// strap synchroniser
	// ****************************************
	logic [3:0] s1_q, s2_q, s3_q;
	logic [3:0] s1_d, s2_d, s3_d;
	// strap is analog-derived, so it crosses in through three flops
	always_comb begin
		s1_d = address_image_strap_pin;
		s2_d = s1_q;
		s3_d = s2_q;
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_q <= 4'h0;
			s2_q <= 4'h0;
			s3_q <= 4'h0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
		end
	end
	wire strap_stable = (s2_q == s3_q);

	// ****************************************
	// power-up sequencer
	// ****************************************
	typedef enum logic [1:0] {ST_SYNC, ST_LOAD, ST_RUN} seq_e;
	seq_e st_q, st_d;
	logic [1:0] sync_cnt_q, sync_cnt_d;
	logic [3:0] code_q, code_d;
	logic [3:0] image_q, image_d;
	logic [1:0] word_q, word_d;
	logic [15:0] base_q, base_d, ctrl_q, ctrl_d, lfz14_q, lfz14_d, lfz0_q, lfz0_d;

	// fixed word to register mapping for the image transfer
	function automatic logic [7:0] word_ofs(input logic [1:0] w);
		case (w)
			2'd0: word_ofs = OFS_BASE_ADDR;
			2'd1: word_ofs = OFS_OFFSET_CTRL;
			2'd2: word_ofs = OFS_LFZ_1_4;
			default: word_ofs = OFS_LFZ_0;
		endcase
	endfunction

	// sequencer and register next state; image load beats software writes
	always_comb begin
		st_d = st_q;
		sync_cnt_d = sync_cnt_q;
		code_d = code_q;
		image_d = image_q;
		word_d = word_q;
		base_d = base_q;
		ctrl_d = ctrl_q;
		lfz14_d = lfz14_q;
		lfz0_d = lfz0_q;
		case (st_q)
			ST_SYNC: begin
				// wait for agreement over a few cycles before latching
				if (!strap_stable) begin
					sync_cnt_d = 2'd0;
				end else if (sync_cnt_q != 2'd3) begin
					sync_cnt_d = sync_cnt_q + 2'd1;
				end else begin
					code_d = s3_q;
					image_d = multi_image_stored ? s3_q : last_programmed_image;
					word_d = 2'd0;
					st_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (nvm_ack) begin
					// copy each image word into its operating register
					case (word_ofs(word_q))
						OFS_BASE_ADDR: base_d = nvm_rdata;
						OFS_OFFSET_CTRL: ctrl_d = nvm_rdata;
						OFS_LFZ_1_4: lfz14_d = nvm_rdata;
						default: lfz0_d = nvm_rdata;
					endcase
					if (word_q == 2'(IMAGE_WORDS - 1)) begin
						st_d = ST_RUN;
					end else begin
						word_d = word_q + 2'd1;
					end
				end
			end
			ST_RUN: begin
				// software writes only after the image is in place
				if (reg_req.wr) begin
					case (reg_req.addr)
						OFS_BASE_ADDR: base_d = reg_req.wdata & 16'h7F7F;
						OFS_OFFSET_CTRL: ctrl_d = reg_req.wdata;
						OFS_LFZ_1_4: lfz14_d = reg_req.wdata & 16'h7777;
						OFS_LFZ_0: lfz0_d = reg_req.wdata & 16'h7000;
						default: ;
					endcase
				end
			end
			default: st_d = ST_SYNC;
		endcase
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= ST_SYNC;
			sync_cnt_q <= 2'd0;
			code_q <= 4'h0;
			image_q <= 4'h0;
			word_q <= 2'd0;
			base_q <= BASE_ADDR_RST;
			ctrl_q <= OFFSET_CTRL_RST;
			lfz14_q <= LFZ_1_4_RST;
			lfz0_q <= LFZ_0_RST;
		end else begin
			st_q <= st_d;
			sync_cnt_q <= sync_cnt_d;
			code_q <= code_d;
			image_q <= image_d;
			word_q <= word_d;
			base_q <= base_d;
			ctrl_q <= ctrl_d;
			lfz14_q <= lfz14_d;
			lfz0_q <= lfz0_d;
		end
	end

	// ****************************************
	// address forming
	// ****************************************
	logic [3:0] pin_offset;
	logic bypass;
	logic [6:0] i2c_base, pmb_base;
	// codes above the limit clamp rather than wrap, so the address never jumps
	always_comb begin
		bypass = ctrl_q[BYPASS_BIT];
		i2c_base = base_q[I2C_ADDR_LSB +: 7];
		pmb_base = base_q[PMB_ADDR_LSB +: 7];
		pin_offset = (code_q > MAX_PIN_OFFSET) ? MAX_PIN_OFFSET : code_q;
		if (bypass) begin
			eff_addr.i2c = i2c_base;
			eff_addr.pmb = pmb_base;
		end else begin
			eff_addr.i2c = i2c_base + {3'b000, pin_offset};
			eff_addr.pmb = pmb_base + {3'b000, pin_offset};
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	// each code v means (v+1) pF of zero capacitance
	assign loop_filter_zero_select = {lfz14_q[LFZ4_LSB +: 3], lfz14_q[LFZ3_LSB +: 3],
		lfz14_q[LFZ2_LSB +: 3], lfz14_q[LFZ1_LSB +: 3], lfz0_q[LFZ0_LSB +: 3]};
	assign strap_code = code_q;
	assign load_done = (st_q == ST_RUN);
	assign nvm_req.req = (st_q == ST_LOAD);
	assign nvm_req.image = image_q;
	assign nvm_req.word = word_q;
	// read data is combinational off the registers; unmapped reads zero
	always_comb begin
		case (reg_req.addr)
			OFS_BASE_ADDR: reg_rdata = base_q;
			OFS_OFFSET_CTRL: reg_rdata = ctrl_q;
			OFS_LFZ_1_4: reg_rdata = lfz14_q;
			OFS_LFZ_0: reg_rdata = lfz0_q;
			default: reg_rdata = 16'h0000;
		endcase
	end

	// ****************************************
	// checks
	// ****************************************
	a_offset_limit: assert property (@(posedge clock) disable iff (rst)
		!bypass |-> (eff_addr.pmb - pmb_base) <= 7'(MAX_PIN_OFFSET))
		else $error("pin offset above limit");
	a_bypass_addr: assert property (@(posedge clock) disable iff (rst)
		bypass |-> eff_addr.i2c == base_q[14:8] && eff_addr.pmb == base_q[6:0])
		else $error("bypass address not base");
	a_sum_addr: assert property (@(posedge clock) disable iff (rst)
		!bypass && code_q <= MAX_PIN_OFFSET |-> eff_addr.i2c == base_q[14:8] + 7'(code_q))
		else $error("offset sum wrong");
	a_code_held: assert property (@(posedge clock) disable iff (rst)
		load_done |=> $stable(code_q) && load_done)
		else $error("strap code changed after power-up");
	a_image_multi: assert property (@(posedge clock) disable iff (rst)
		nvm_req.req && multi_image_stored |-> nvm_req.image == code_q)
		else $error("image not strap code");
	a_image_single: assert property (@(posedge clock) disable iff (rst)
		nvm_req.req && !multi_image_stored |-> nvm_req.image == last_programmed_image)
		else $error("image not last programmed");
	a_load_end: assert property (@(posedge clock) disable iff (rst)
		nvm_req.req && nvm_ack && word_q == 2'd3 |=> load_done)
		else $error("load did not finish");
	a_both_ports: assert property (@(posedge clock) disable iff (rst)
		(eff_addr.i2c - i2c_base) == (eff_addr.pmb - pmb_base))
		else $error("ports offset differ");
	a_lfz_write: assert property (@(posedge clock) disable iff (rst)
		load_done && reg_req.wr && reg_req.addr == OFS_LFZ_0
		|=> loop_filter_zero_select[2:0] == $past(reg_req.wdata[14:12]))
		else $error("zero select 0 not written");

	// ****************************************
	// image load checks
	// ****************************************
	// one accepted image word, split by where it falls in the image
	sequence s_beat;
		nvm_req.req && nvm_ack;
	endsequence
	sequence s_first_beat;
		s_beat ##0 word_q == 2'd0;
	endsequence
	sequence s_mid_beat;
		s_beat ##0 word_q != 2'(IMAGE_WORDS - 1);
	endsequence
	sequence s_last_beat;
		s_beat ##0 word_q == 2'(IMAGE_WORDS - 1);
	endsequence
	// a word stays offered until taken, so a slow store never sees a moving request
	a_req_hold: assert property (@(posedge clock) disable iff (rst)
		nvm_req.req && !nvm_ack
		|=> nvm_req.req && $stable(nvm_req.word) && $stable(nvm_req.image))
		else $error("image request moved before answer");
	// each taken word but the last moves the request on by exactly one
	a_word_step: assert property (@(posedge clock) disable iff (rst)
		s_mid_beat |=> nvm_req.req && nvm_req.word == $past(word_q) + 2'd1)
		else $error("image word did not advance");
	// first and last words land in their operating registers
	a_base_copy: assert property (@(posedge clock) disable iff (rst)
		s_first_beat |=> base_q == $past(nvm_rdata))
		else $error("first image word not in base register");
	a_lfz_default: assert property (@(posedge clock) disable iff (rst)
		s_last_beat |=> loop_filter_zero_select[2:0] == $past(nvm_rdata[LFZ0_LSB +: 3]))
		else $error("zero select 0 not taken from image");
	// nothing but the image may touch the registers before the load ends
	a_wr_ignored: assert property (@(posedge clock) disable iff (rst)
		!load_done && !nvm_ack
		|=> $stable(base_q) && $stable(ctrl_q) && $stable(lfz14_q) && $stable(lfz0_q))
		else $error("register changed before image load");
	// the code comes from the settled strap in the cycle before the load starts
	a_code_latch: assert property (@(posedge clock) disable iff (rst)
		$rose(nvm_req.req) |-> $past(strap_stable) && code_q == $past(s3_q))
		else $error("strap code not latched from settled pin");

	// ****************************************
	// address and register checks
	// ****************************************
	// once loaded, a strap that wanders must not move the address
	a_addr_held: assert property (@(posedge clock) disable iff (rst)
		load_done && !reg_req.wr |=> $stable(eff_addr))
		else $error("address moved without a write");
	// codes past the limit give the limit itself, never a wrapped sum
	a_offset_clamp: assert property (@(posedge clock) disable iff (rst)
		!bypass && code_q > MAX_PIN_OFFSET |-> eff_addr.pmb == pmb_base + 7'(MAX_PIN_OFFSET))
		else $error("large code not clamped");
	a_pmb_sum: assert property (@(posedge clock) disable iff (rst)
		!bypass && code_q <= MAX_PIN_OFFSET |-> eff_addr.pmb == base_q[6:0] + 7'(code_q))
		else $error("pmbus offset sum wrong");
	// software writes reach the fields they name
	a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
		load_done && reg_req.wr && reg_req.addr == OFS_OFFSET_CTRL
		|=> bypass == $past(reg_req.wdata[BYPASS_BIT]))
		else $error("bypass bit not written");
	// software writes clear the reserved bits, so a read-back after a write never shows an eighth address bit; image words are copied unmasked
	a_base_mask: assert property (@(posedge clock) disable iff (rst)
		load_done && reg_req.wr && reg_req.addr == OFS_BASE_ADDR
		|=> base_q[14:8] == $past(reg_req.wdata[14:8])
		&& base_q[6:0] == $past(reg_req.wdata[6:0])
		&& !base_q[15] && !base_q[7])
		else $error("base address fields not written");
	a_lfz_fields: assert property (@(posedge clock) disable iff (rst)
		load_done && reg_req.wr && reg_req.addr == OFS_LFZ_1_4
		|=> loop_filter_zero_select[14:3] == {$past(reg_req.wdata[14:12]),
		$past(reg_req.wdata[10:8]), $past(reg_req.wdata[6:4]), $past(reg_req.wdata[2:0])})
		else $error("zero selects 1 to 4 not written");
endmodule

// [verif/nvm_model.sv]
// image store model that answers word reads after a chosen delay
`timescale 1ns/100ps
module nvm_model (
	// clock
	input wire logic clock,
	// read request and answer delay
	input strap_pkg::nvm_req_s nvm_req,
	input wire logic [3:0] slow,
	// answer
	output logic nvm_ack,
	output logic [15:0] nvm_rdata
);
	import strap_pkg::*;
	int cnt = 0;
	// answer after slow idle cycles; data toggles when not valid so stale words never match
	always @(posedge clock) begin
		#1;
		if (nvm_req.req && !nvm_ack && cnt >= slow) begin
			nvm_ack = 1'b1;
			nvm_rdata = {2'b00, nvm_req.word, nvm_req.image, 4'h0, nvm_req.image};
			cnt = 0;
		end else begin
			nvm_ack = 1'b0;
			nvm_rdata = ~nvm_rdata;
			cnt = nvm_req.req ? cnt + 1 : 0;
		end
	end
endmodule

// [verif/strap_address_image_select_tb.sv]
// self-checking bench for the strap address and image select block
`timescale 1ns/100ps
module strap_address_image_select_tb;
	import strap_pkg::*;
	// ************
	// signals
	// ************
	logic clock = 0, rst = 1, multi = 0, nvm_ack, done;
	logic [3:0] pin = 0, last = 0, slow = 0, code;
	logic [15:0] nvm_rdata, rdata, base, exp_q[$];
	logic [14:0] lfz;
	logic [6:0] img, off;
	logic [3:0] codes[4] = '{4'h0, 4'h4, 4'h5, 4'hF};
	string names[4] = '{"strap_code", "reg_rdata", "eff_addr", "loop_filter_zero_select"};
	int sel_q[$];
	int s, err_total = 0, comparisons = 0, seed = 51;
	nvm_req_s nreq;
	reg_req_s req = '0;
	addr_pair_s eff;
	strap_address_image_select uut (.clock(clock), .rst(rst), .address_image_strap_pin(pin),
		.multi_image_stored(multi), .last_programmed_image(last), .nvm_req(nreq),
		.nvm_ack(nvm_ack), .nvm_rdata(nvm_rdata), .reg_req(req), .reg_rdata(rdata),
		.eff_addr(eff), .strap_code(code), .load_done(done), .loop_filter_zero_select(lfz));
	nvm_model nvm (.clock(clock), .nvm_req(nreq), .slow(slow), .nvm_ack(nvm_ack),
		.nvm_rdata(nvm_rdata));
	always #50 clock = ~clock;
	// ************
	// tasks
	// ************
	task automatic note(int k, logic [15:0] v);
		sel_q.push_back(k);
		exp_q.push_back(v);
	endtask
	task automatic check(string n, logic [15:0] seen, logic [15:0] e);
		comparisons++;
		if (seen !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [15:0] d);
		@(posedge clock) #1 req = '{1'b1, 1'b0, a, d};
		@(posedge clock) #1 req.wr = 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [15:0] e);
		@(posedge clock) #1 req.addr = a;
		note(1, e);
	endtask
	task automatic finish_test();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// monitor: outputs are settled by the falling edge, oldest note first
	always @(negedge clock) begin
		while (exp_q.size() > 0) begin
			s = sel_q.pop_front();
			check(names[s], s == 0 ? 16'(code) : s == 1 ? rdata : s == 2 ? 16'(eff) :
				16'(lfz), exp_q.pop_front());
		end
	end
	// watchdog so a stuck load still reaches the report
	initial begin
		#3000000;
		err_total++;
		finish_test();
	end
	// ************
	// main sequence
	// ************
	// codes 4 and 5 straddle the offset clamp; each pass is a fresh power-up
	initial begin
		for (int r = 0; r < 4; r++) begin
			rst = 1'b1;
			pin = codes[r];
			multi = r[0];
			last = 4'($random(seed));
			slow = 4'($random(seed));
			repeat (5) @(posedge clock);
			#1 rst = 1'b0;
			// a write before the image is in place must be dropped
			wr(OFS_LFZ_0, 16'h7000);
			for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge clock) #1;
			if (done !== 1'b1) begin
				err_total++;
				finish_test();
			end
			img = multi ? 7'(pin) : 7'(last);
			off = pin > 4 ? 7'd4 : 7'(pin);
			note(0, 16'(codes[r]));
			rd(OFS_BASE_ADDR, {4'h0, img[3:0], 4'h0, img[3:0]});
			note(2, {2'b00, img + off, img + off});
			note(3, {1'b0, 3'd2, img[2:0], 3'd0, img[2:0], 3'd3});
			// a strap that moves after power-up must change nothing
			pin = ~pin;
			repeat (10) @(posedge clock);
			note(0, 16'(codes[r]));
			wr(OFS_OFFSET_CTRL, 16'h0040);
			base = 16'($random(seed));
			wr(OFS_BASE_ADDR, base);
			base = base & 16'h7F7F;
			rd(OFS_BASE_ADDR, base);
			note(2, {2'b00, base[14:8], base[6:0]});
			// every control bit but the bypass set, so only bit 6 may steer the address
			wr(OFS_OFFSET_CTRL, 16'hFFBF);
			note(2, {2'b00, base[14:8] + off, base[6:0] + off});
			rd(OFS_OFFSET_CTRL, 16'hFFBF);
			// reserved bits set on purpose; they must read back as zero
			wr(OFS_LFZ_1_4, 16'hF654);
			wr(OFS_LFZ_0, 16'hDFFF);
			note(3, 16'h7D65);
			rd(OFS_LFZ_1_4, 16'h7654);
			rd(OFS_LFZ_0, 16'h5000);
			rd(8'h30, 16'h0000);
			@(posedge clock) #1;
		end
		finish_test();
	end
endmodule
